/* logic/crc_spi_config.v */
// serial configuration port with keepalive timer, phase clocks and gate latches
`default_nettype none
`include "crc_spi_config_regs.vh"

// Function
// RULE_01 - write-only serial port loads one 12-bit command register, no readback
// RULE_02 - host always sends command bit 11 as zero
// RULE_03 - bit 10 selects four-times faster soft-start; default zero; watchdog keeps it
// RULE_04 - bit 9 keeps phase two at light load; default zero; watchdog keeps it
// RULE_05 - bit 8 enables clock output pin; default zero; watchdog keeps it
// RULE_06 - bit 7 sets clock output phase: zero ninety, one forty-five degrees
// RULE_07 - bits 6..0 hold twice the target voltage minus nine volts
// RULE_08 - watchdog expiry restores only the voltage field to the strap default
// RULE_09 - each frame is a 4-bit check code ahead of the 12-bit word
// RULE_10 - with watchdog on, a valid command every 20 ms or defaults return
// RULE_11 - check code is crc with polynomial x^4 + x + 1 over the word
// RULE_12 - crc register seeds to all ones so an all-zero frame fails
// RULE_13 - host builds the code with the shift-and-reduce reference routine
// RULE_14 - mode at supply rail: 60 V start, watchdog on, 60 V on expiry
// RULE_15 - mode at half rail or open: 36 V start and 36 V on expiry
// RULE_16 - mode grounded: no watchdog, start-up waits for a valid command
// RULE_17 - phase two stops below 12.5 percent, restarts above 25 percent
// RULE_18 - the two phase clocks sit 180 degrees apart
// RULE_19 - per phase latch set by clock, gate on while set, reset on overcurrent
// RULE_20 - clock output of one part feeds sync input of the next; this part has no sync input, its switching divider free-runs
// RULE_21 - data bits captured on rising serial clock edges
// RULE_22 - host frames each command with chip select while shifting data
// RULE_23 - disabled clock output pin is released to high impedance
// RULE_24 - msb first, crc first, one select; evaluated when select releases
// RULE_25 - frames not sixteen bits or failing crc change nothing
module crc_spi_config #(
  parameter [20:0] WDOG_CYCLES = `WDOG_CYC
) (
  input wire mclk,
  input wire rst_b,
  input wire spi_clk,
  input wire spi_sel_b,
  input wire serial_data_in,
  input wire [1:0] mode_strap,
  input wire enable_pin,
  input wire phase1_over_limit,
  input wire phase2_over_limit,
  input wire load_below_low,
  input wire load_above_high,
  output wire [6:0] vout_code,
  output wire soft_start_fast,
  output reg regulator_run_ff,
  output reg phase1_gate_drive_ff,
  output reg phase2_gate_drive_ff,
  output reg clock_out_pin_ff,
  output reg clock_out_pin_oe_b_ff
);

  // synchroniser stages for every pin input
  reg [1:0] sck_sync_ff;
  reg [1:0] sel_sync_ff;
  reg [1:0] sdi_sync_ff;
  reg [1:0] en_sync_ff;
  reg [1:0] oc1_sync_ff;
  reg [1:0] oc2_sync_ff;
  reg [1:0] lo_sync_ff;
  reg [1:0] hi_sync_ff;
  reg [3:0] mode_sync_ff;
  reg sck_prev_ff;
  reg sel_prev_ff;

  // receive path
  reg [15:0] shift_ff;
  reg [4:0] bit_cnt_ff;
  reg [11:0] config_command_word_ff;

  // strap capture and watchdog
  reg [1:0] strap_cnt_ff;
  reg strap_done_ff;
  reg [1:0] mode_ff;
  reg [6:0] vout_dflt_ff;
  reg target_valid_ff;
  reg [20:0] wdog_cnt_ff;

  // switching clocks and phase state
  reg [7:0] sw_cnt_ff;
  reg phase2_active_ff;
  reg latch1_ff;
  reg latch2_ff;

  wire sck_s;
  wire sel_s;
  wire sdi_s;
  wire en_s;
  wire sck_rise;
  wire sel_rise;
  wire [3:0] crc_calc;
  wire frame_ok;
  wire wdog_on;
  wire wdog_expire;
  wire pulse1;
  wire pulse2;
  wire [7:0] cko_start;
  wire [7:0] cko_stop;

  // second stage only feeds logic; first stage is read by nothing else
  assign sck_s = sck_sync_ff[1];
  assign sel_s = sel_sync_ff[1];
  assign sdi_s = sdi_sync_ff[1];
  assign en_s = en_sync_ff[1];

  // the serial clock is slow next to mclk, so edges are found by sampling
  assign sck_rise = sck_s & ~sck_prev_ff;
  assign sel_rise = sel_s & ~sel_prev_ff;

  crc4_check u_crc (
    .word(shift_ff[11:0]),
    .crc(crc_calc)
  );

  // exact length and matching code, judged when select goes high
  assign frame_ok = sel_rise && (bit_cnt_ff == `FRAME_BITS) && // RULE_24 RULE_25
    (shift_ff[15:12] == crc_calc); // RULE_09 RULE_11

  assign wdog_on = strap_done_ff && (mode_ff != `MODE_GND); // RULE_16
  assign wdog_expire = wdog_on && (wdog_cnt_ff == WDOG_CYCLES - 21'h1); // RULE_10

  // field outputs come straight from the command register
  assign vout_code = config_command_word_ff[`VOUT_MSB:`VOUT_LSB]; // RULE_07
  assign soft_start_fast = config_command_word_ff[`BIT_SS_FAST]; // RULE_03

  // two-flop synchronisers
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sck_sync_ff <= 2'b00;
      sel_sync_ff <= 2'b11;
      sdi_sync_ff <= 2'b00;
      en_sync_ff <= 2'b00;
      oc1_sync_ff <= 2'b00;
      oc2_sync_ff <= 2'b00;
      lo_sync_ff <= 2'b00;
      hi_sync_ff <= 2'b00;
      mode_sync_ff <= 4'h0;
      sck_prev_ff <= 1'b0;
      sel_prev_ff <= 1'b1;
    end else begin
      sck_sync_ff <= {sck_sync_ff[0], spi_clk};
      sel_sync_ff <= {sel_sync_ff[0], spi_sel_b};
      sdi_sync_ff <= {sdi_sync_ff[0], serial_data_in};
      en_sync_ff <= {en_sync_ff[0], enable_pin};
      oc1_sync_ff <= {oc1_sync_ff[0], phase1_over_limit};
      oc2_sync_ff <= {oc2_sync_ff[0], phase2_over_limit};
      lo_sync_ff <= {lo_sync_ff[0], load_below_low};
      hi_sync_ff <= {hi_sync_ff[0], load_above_high};
      mode_sync_ff <= {mode_sync_ff[1:0], mode_strap};
      sck_prev_ff <= sck_s;
      sel_prev_ff <= sel_s;
    end
  end

  // shift in msb first on rising serial clock while selected; count saturates
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      shift_ff <= 16'h0000;
      bit_cnt_ff <= 5'h00;
    end else if (sel_s) begin
      bit_cnt_ff <= 5'h00; // RULE_24
    end else if (sck_rise) begin
      shift_ff <= {shift_ff[14:0], sdi_s}; // RULE_21 RULE_24
      if (bit_cnt_ff != `CNT_SAT) begin
        bit_cnt_ff <= bit_cnt_ff + 5'h01;
      end
    end
  end

  // strap is read a few cycles after release, once the synchroniser holds real data
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt_ff <= 2'b00;
      strap_done_ff <= 1'b0;
      mode_ff <= `MODE_GND;
      vout_dflt_ff <= `VOUT_RST;
    end else if (!strap_done_ff) begin
      strap_cnt_ff <= strap_cnt_ff + 2'b01;
      if (strap_cnt_ff == 2'b11) begin
        strap_done_ff <= 1'b1;
        mode_ff <= mode_sync_ff[3:2];
        if (mode_sync_ff[3:2] == `MODE_HALF) begin
          vout_dflt_ff <= `VOUT_36V; // RULE_15
        end else if (mode_sync_ff[3:2] != `MODE_GND) begin
          vout_dflt_ff <= `VOUT_60V; // RULE_14
        end
      end
    end
  end

  // command register: write only, no path back to the host
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      config_command_word_ff <= {1'b0, `CTRL_RST, `VOUT_RST};
      target_valid_ff <= 1'b0;
    end else if (frame_ok) begin
      // reserved bit 11 is stored but steers nothing
      config_command_word_ff <= shift_ff[11:0]; // RULE_01
      target_valid_ff <= 1'b1; // RULE_16
    end else if (wdog_expire) begin
      // only the voltage field returns; control bits stay as written
      config_command_word_ff[`VOUT_MSB:`VOUT_LSB] <= vout_dflt_ff; // RULE_08
    end else if (strap_done_ff && !target_valid_ff && mode_ff != `MODE_GND) begin
      config_command_word_ff[`VOUT_MSB:`VOUT_LSB] <= vout_dflt_ff; // RULE_14 RULE_15
      target_valid_ff <= 1'b1;
    end
  end

  // keepalive timer: a valid frame restarts it, a bad frame leaves it alone
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      wdog_cnt_ff <= 21'h000000;
    end else if (!wdog_on || frame_ok || wdog_expire) begin
      wdog_cnt_ff <= 21'h000000; // RULE_10 RULE_25
    end else begin
      wdog_cnt_ff <= wdog_cnt_ff + 21'h000001;
    end
  end

  // start-up waits for enable, the strap and a programmed target
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      regulator_run_ff <= 1'b0;
    end else begin
      regulator_run_ff <= en_s && strap_done_ff && target_valid_ff; // RULE_16
    end
  end

  // switching clock divider; stands in for the oscillator
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      sw_cnt_ff <= 8'h00;
    end else if (sw_cnt_ff == `SW_PERIOD - 8'h01) begin
      sw_cnt_ff <= 8'h00;
    end else begin
      sw_cnt_ff <= sw_cnt_ff + 8'h01;
    end
  end

  // phase pulses half a period apart
  assign pulse1 = (sw_cnt_ff == 8'h00); // RULE_18
  assign pulse2 = (sw_cnt_ff == `SW_HALF); // RULE_18

  // light-load dropping with hysteresis between the two thresholds
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase2_active_ff <= 1'b1;
    end else if (config_command_word_ff[`BIT_PH2_KEEP]) begin
      phase2_active_ff <= 1'b1; // RULE_04
    end else if (lo_sync_ff[1]) begin
      phase2_active_ff <= 1'b0; // RULE_17
    end else if (hi_sync_ff[1]) begin
      phase2_active_ff <= 1'b1; // RULE_17
    end
  end

  // set-reset latches; the set pulse wins so a stale overcurrent cannot skip a cycle
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      latch1_ff <= 1'b0;
      latch2_ff <= 1'b0;
    end else begin
      if (!regulator_run_ff) begin
        latch1_ff <= 1'b0;
      end else if (pulse1) begin
        latch1_ff <= 1'b1; // RULE_19
      end else if (oc1_sync_ff[1]) begin
        latch1_ff <= 1'b0; // RULE_19
      end
      if (!regulator_run_ff || !phase2_active_ff) begin
        latch2_ff <= 1'b0; // RULE_17
      end else if (pulse2) begin
        latch2_ff <= 1'b1; // RULE_19
      end else if (oc2_sync_ff[1]) begin
        latch2_ff <= 1'b0; // RULE_19
      end
    end
  end

  // gate drives follow the latches, registered so the pins come from flops
  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      phase1_gate_drive_ff <= 1'b0;
      phase2_gate_drive_ff <= 1'b0;
    end else begin
      phase1_gate_drive_ff <= latch1_ff; // RULE_19
      phase2_gate_drive_ff <= latch2_ff; // RULE_19
    end
  end

  // clock output rises at the chosen offset after phase one and lasts half a period
  assign cko_start = config_command_word_ff[`BIT_CKO_45] ? `SW_EIGHTH : `SW_QUARTER; // RULE_06
  assign cko_stop = cko_start + `SW_HALF;

  always @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      clock_out_pin_ff <= 1'b0;
      clock_out_pin_oe_b_ff <= 1'b1;
    end else begin
      clock_out_pin_oe_b_ff <= ~config_command_word_ff[`BIT_CKO_EN]; // RULE_05 RULE_23
      if (sw_cnt_ff == cko_start) begin
        clock_out_pin_ff <= 1'b1; // RULE_06
      end else if (sw_cnt_ff == cko_stop) begin
        clock_out_pin_ff <= 1'b0;
      end
    end
  end

endmodule // crc_spi_config
`default_nettype wire

/* logic/crc_spi_config_regs.vh */
// constants of the serial configuration port and its watchdog
`ifndef CRC_SPI_CONFIG_REGS_VH
`define CRC_SPI_CONFIG_REGS_VH

// command word layout
`define CMD_W 12
`define FRAME_BITS 5'd16
`define CNT_SAT 5'd17
`define CRC_W 4
`define BIT_RSVD 11
`define BIT_SS_FAST 10
`define BIT_PH2_KEEP 9
`define BIT_CKO_EN 8
`define BIT_CKO_45 7
`define VOUT_MSB 6
`define VOUT_LSB 0

// reset values: control bits and voltage code zero; strap defaults for the voltage code follow
`define CTRL_RST 4'h0
`define VOUT_RST 7'h00
`define VOUT_60V 7'h66
`define VOUT_36V 7'h36

// crc generator and step count
`define CRC_DIV 16'h9800
`define CRC_STEPS 12

// mode strap codes
`define MODE_GND 2'b00
`define MODE_HALF 2'b01

// watchdog: 20 ms at 100 MHz
`define WDOG_MS 21'd20
`define CLK_KHZ 21'd100000
`define WDOG_CYC (`WDOG_MS * `CLK_KHZ)

// switching clock divider and phase points; a period divisible by eight keeps 45 degrees exact
`define SW_PERIOD 8'd96
`define SW_HALF (`SW_PERIOD >> 1)
`define SW_QUARTER (`SW_PERIOD >> 2)
`define SW_EIGHTH (`SW_PERIOD >> 3)

`endif

/* logic/crc4_check.v */
// four-bit check code generator for a twelve-bit command word
`default_nettype none
`include "crc_spi_config_regs.vh"

module crc4_check (
  input wire [11:0] word,
  output reg [3:0] crc
);

  reg [15:0] x;
  reg [15:0] p;
  integer i;

  // long division by a shifting divisor; the final flip of bit 0 carries the all-ones seed
  always @* begin
    x = {1'b0, word, 3'b000};
    p = `CRC_DIV;
    for (i = 0; i < `CRC_STEPS; i = i + 1) begin
      if ((x ^ p) < x) begin
        x = x ^ p; // RULE_11
      end
      p = p >> 1;
    end
    crc = x[3:0] ^ 4'h1; // RULE_12
  end

endmodule // crc4_check
`default_nettype wire

/* tb/crc_spi_config_checker.sv */
// assertion checker on the pins of the configuration port
`default_nettype none
module crc_spi_config_checker #(
  parameter [20:0] WDOG_CYCLES = 21'd2000000
) (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic spi_sel_b,
  input wire logic [1:0] mode_strap,
  input wire logic phase1_over_limit,
  input wire logic [6:0] vout_code,
  input wire logic soft_start_fast,
  input wire logic regulator_run_ff,
  input wire logic phase1_gate_drive_ff,
  input wire logic phase2_gate_drive_ff,
  input wire logic clock_out_pin_ff,
  input wire logic clock_out_pin_oe_b_ff
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);
  logic [3:0] age_ff;
  logic [2:0] rel_ff;
  // saturating ages since select rose and since reset ended
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      age_ff <= 4'hf;
      rel_ff <= 3'h0;
    end else begin
      age_ff <= spi_sel_b ? age_ff + {3'h0, age_ff != 4'hf} : 4'h0;
      rel_ff <= rel_ff + {2'h0, rel_ff != 3'h7};
    end
  end
  a_rail_default: assert property (
    rel_ff == 3'h6 && mode_strap[1] |-> vout_code == 7'h66) else $error("rail default");
  // fields move only just after a frame; the voltage may also fall back to its default
  a_vout_by_frame: assert property (
    $changed(vout_code) && rel_ff == 3'h7 |-> age_ff inside {[2:9]} ||
    (mode_strap != 2'h0 && vout_code == (mode_strap[1] ? 7'h66 : 7'h36)))
    else $error("vout moved");
  a_fast_by_frame: assert property (
    $changed(soft_start_fast) |-> age_ff inside {[2:9]}) else $error("fast moved");
  a_oe_by_frame: assert property (
    $changed(clock_out_pin_oe_b_ff) |-> age_ff inside {[2:9]}) else $error("oe moved");
  a_idle_gates: assert property (
    (!regulator_run_ff) [*3] |-> !phase1_gate_drive_ff && !phase2_gate_drive_ff)
    else $error("gate while idle");
  // set wins for one cycle, so the gate may pulse once while tripped
  a_trip_gate: assert property (
    phase1_over_limit [*6] |-> ##[0:1] !phase1_gate_drive_ff) else $error("no trip");
  a_half_period: assert property (
    $rose(phase1_gate_drive_ff) && $past(regulator_run_ff, 2) |=>
    (!$rose(phase2_gate_drive_ff)) [*8]) else $error("phases close");
  a_cko_offset: assert property (
    $rose(phase1_gate_drive_ff) && !clock_out_pin_oe_b_ff && age_ff == 4'hf |->
    ##[9:13] $rose(clock_out_pin_ff) or ##[21:26] $rose(clock_out_pin_ff))
    else $error("cko offset");
endmodule // crc_spi_config_checker

bind crc_spi_config crc_spi_config_checker #(.WDOG_CYCLES(WDOG_CYCLES)) chk (
  .mclk, .rst_b, .spi_sel_b, .mode_strap, .phase1_over_limit, .vout_code, .soft_start_fast,
  .regulator_run_ff, .phase1_gate_drive_ff, .phase2_gate_drive_ff, .clock_out_pin_ff,
  .clock_out_pin_oe_b_ff);
`default_nettype wire

/* tb/spi_host_model.sv */
// host model that frames and shifts commands into the port
`default_nettype none
module spi_host_model (
  input wire logic mclk,
  output var logic spi_clk,
  output var logic spi_sel_b,
  output var logic serial_data_in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    spi_clk = 1'b0;
    spi_sel_b = 1'b1;
    serial_data_in = 1'b0;
  end
  // check code prepended the way the host routine builds it
  function automatic logic [15:0] add_crc(input logic [11:0] w);
    logic [15:0] x;
    logic [15:0] p;
    x = {1'b0, w, 3'h0};
    p = 16'h9800;
    for (int i = 0; i < 12; i++) begin
      if ((x ^ p) < x) x = x ^ p;
      p = p >> 1;
    end
    return {x[3:0] ^ 4'h1, w};
  endfunction
  // clock idles low; data flips on release since the line has no pull
  task automatic send(input logic [31:0] f, input int n);
    spi_sel_b <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      serial_data_in <= f[i];
      repeat (8) @(posedge mclk);
      spi_clk <= 1'b1;
      repeat (8) @(posedge mclk);
      spi_clk <= 1'b0;
    end
    repeat (8) @(posedge mclk);
    spi_sel_b <= 1'b1;
    serial_data_in <= ~serial_data_in;
    repeat (8) @(posedge mclk);
  endtask
endmodule // spi_host_model
`default_nettype wire

/* tb/test_crc_spi_config.sv */
// self-checking bench for the serial configuration port
`default_nettype none
`include "crc_spi_config_regs.vh"
module test_crc_spi_config;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [20:0] WDOG = 21'd3000;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic [1:0] mode_strap = 2'h2;
  logic enable_pin = 1'b1;
  logic phase1_over_limit = 1'b0;
  logic phase2_over_limit = 1'b0;
  logic load_below_low = 1'b0;
  logic load_above_high = 1'b0;
  logic ovc_hold = 1'b0;
  logic [31:0] seed = 32'h3a88;
  logic [11:0] cur = 12'h0;
  wire spi_clk, spi_sel_b, serial_data_in, soft_start_fast, regulator_run_ff;
  wire phase1_gate_drive_ff, phase2_gate_drive_ff, clock_out_pin_ff, clock_out_pin_oe_b_ff;
  wire [6:0] vout_code;
  int num_errors = 0;
  int checks = 0;
  int cycles = 0;
  int n = 0;
  crc_spi_config #(.WDOG_CYCLES(WDOG)) DUT (
    .mclk, .rst_b, .spi_clk, .spi_sel_b, .serial_data_in, .mode_strap, .enable_pin,
    .phase1_over_limit, .phase2_over_limit, .load_below_low, .load_above_high, .vout_code,
    .soft_start_fast, .regulator_run_ff, .phase1_gate_drive_ff, .phase2_gate_drive_ff,
    .clock_out_pin_ff, .clock_out_pin_oe_b_ff);
  spi_host_model host (.mclk, .spi_clk, .spi_sel_b, .serial_data_in);
  always #5 mclk = ~mclk;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // random source; sense trips are frequent so pulses mostly end early on a trip
  always @(posedge mclk) begin
    seed <= lfsr(seed);
    phase1_over_limit <= ovc_hold | (&seed[2:0]);
    phase2_over_limit <= &seed[5:3];
  end
  // hang guard
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic check(input string what, input logic [6:0] seen, input logic [6:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic restart(input logic [1:0] m);
    @(posedge mclk);
    rst_b <= 1'b0;
    mode_strap <= m;
    cur = 12'h0;
    repeat (20) @(posedge mclk);
    rst_b <= 1'b1;
    repeat (12) @(posedge mclk);
  endtask
  task automatic cmd(input logic [11:0] w);
    host.send({16'h0, host.add_crc(w)}, 16);
    cur = w;
    repeat (12) @(posedge mclk);
  endtask
  task automatic expect_word(input logic [6:0] v);
    check("vout", vout_code, v);
    check("fast", {6'h0, soft_start_fast}, {6'h0, cur[10]});
    check("oe_b", {6'h0, clock_out_pin_oe_b_ff}, {6'h0, ~cur[8]});
  endtask
  task automatic count_p2(input logic exp);
    repeat (20) @(posedge mclk);
    n = 0;
    repeat (200) @(negedge mclk) n += int'(phase2_gate_drive_ff);
    check("phase2", {6'h0, n != 0}, {6'h0, exp});
  endtask
  // lag from phase one gate to clock out, then clock out period as a chained part sees it
  task automatic cko_check(input logic b45);
    @(posedge phase1_gate_drive_ff);
    n = 0;
    while (!clock_out_pin_ff && n < 300) begin
      @(posedge mclk);
      n++;
    end
    check("cko_lag", 7'(n), 7'(b45 ? `SW_PERIOD / 8 : `SW_PERIOD / 4));
    n = 0;
    while (clock_out_pin_ff && n < 300) begin
      @(posedge mclk);
      n++;
    end
    while (!clock_out_pin_ff && n < 300) begin
      @(posedge mclk);
      n++;
    end
    check("cko_period", 7'(n), 7'(`SW_PERIOD));
  endtask
  initial begin
    restart(2'h2);
    expect_word(7'h66);
    check("run", {6'h0, regulator_run_ff}, 7'h1);
    for (int i = 0; i < 8; i++) begin
      cmd(i == 0 ? 12'h7e6 : i == 1 ? 12'h000 : {1'b0, seed[10:7], 7'(seed[31:8] % 103)});
      expect_word(cur[6:0]);
      if (i < 2) cko_check(cur[7]);
    end
    $display("test commands done");
    host.send({16'h0, host.add_crc(12'h123) ^ 16'h4000}, 16);
    host.send({16'h0, host.add_crc(12'h123)}, 15);
    host.send({16'h0, host.add_crc(12'h123)}, 17);
    host.send(32'h0, 16);
    repeat (12) @(posedge mclk);
    expect_word(cur[6:0]);
    $display("test refused frames done");
    cmd(12'h7a0);
    repeat (WDOG - 500) @(posedge mclk);
    host.send(32'h0, 16);
    expect_word(7'h20);
    repeat (250) @(posedge mclk);
    expect_word(7'h66);
    $display("test keepalive done");
    load_below_low <= 1'b1;
    cmd(12'h200);
    count_p2(1'b1);
    cmd(12'h000);
    count_p2(1'b0);
    // change load away from a phase one set so a late phase two start stays legal
    @(posedge phase1_gate_drive_ff);
    repeat (20) @(posedge mclk);
    load_below_low <= 1'b0;
    load_above_high <= 1'b1;
    count_p2(1'b1);
    ovc_hold <= 1'b1;
    repeat (120) @(posedge mclk);
    ovc_hold <= 1'b0;
    $display("test phases done");
    restart(2'h1);
    expect_word(7'h36);
    restart(2'h0);
    expect_word(7'h00);
    check("run", {6'h0, regulator_run_ff}, 7'h0);
    cmd(12'h12c);
    check("run", {6'h0, regulator_run_ff}, 7'h1);
    // enable low must stop start-up even with a valid target
    enable_pin <= 1'b0;
    repeat (5) @(posedge mclk);
    check("run_en", {6'h0, regulator_run_ff}, 7'h0);
    enable_pin <= 1'b1;
    repeat (WDOG + 100) @(posedge mclk);
    expect_word(7'h2c);
    $display("test straps done");
    report_and_stop();
  end
endmodule // test_crc_spi_config
`default_nettype wire
